// [ddr3_cmd_pkg.sv]
// Constants of the DDR3 command-side block: command codes, mode fields,
// write timing and reset values.
// Assumes one 20 MHz system clock that oversamples the memory clock pins.
// ****************************************************************
// How it works
// [RQ1] Controller spaces read to precharge by additive latency plus delay.
// [RQ2] Read-to-precharge delay is at least max of four clocks, 7.5 ns.
// [RQ3] Controller also honours activate-to-precharge minimum first.
// [RQ4] New activate waits precharge period and row cycle time both.
// [RQ5] On the fly, A12 low chops to four beats, high gives eight.
// [RQ6] A12 on reads and writes only picks burst length, never column.
// [RQ7] Chopped bursts still keep four clocks between column commands.
// [RQ8] Mode zero field 00 gives eight beats; 01 lets A12 choose.
// [RQ9] Mode zero field 10 forces chopped four-beat reads and writes.
// [RQ10] Bad write strobe timing corrupts only that location, never hangs.
// [RQ11] One mask line per eight data lines, sampled like the data.
// [RQ12] Mask ignored on reads; acts as termination strobe when enabled.
// [RQ13] Controller counts write-to-read delay after the last write beat.
// [RQ14] Controller counts write recovery after last beat before precharge.
// [RQ15] Chip select, row and column strobes low, write high: refresh.
// [RQ16] Controller precharges all banks for precharge period before refresh.
// [RQ17] Refresh row comes from internal counter; all banks end idle.
// [RQ18] After refresh only no-op or deselect until refresh cycle time.
// [RQ19] Average refresh interval kept; at most eight postponed.
// [RQ20] Up to eight refreshes pulled in; more give no credit.
// [RQ21] No more than sixteen refreshes within two average intervals.
// [RQ22] Postponed count frozen during self-refresh, total never above eight.
// [RQ23] Controller tracks signed refresh debt bounded by plus, minus eight; the model caps only the pulled-in side at eight.
package ddr3_cmd_pkg;
   // ****************************************************************
   // Command codes {cs_n, ras_n, cas_n, we_n}
   // ****************************************************************
   localparam logic [3:0] CMD_MODE = 4'h0;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_ACTIVATE = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ = 4'h5;
   // ****************************************************************
   // Address fields and mode register selects
   // ****************************************************************
   localparam int BL_SELECT_BIT = 12;
   localparam int AUTO_PRE_BIT = 10;
   localparam int TERM_STROBE_BIT = 11;
   localparam int COL_WIDTH = 10;
   localparam logic [2:0] SEL_MODE_ZERO = 3'h0;
   localparam logic [2:0] SEL_MODE_ONE = 3'h1;
   localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
   localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
   localparam logic [1:0] BL_FIXED_FOUR = 2'h2;
   // ****************************************************************
   // Write timing and reset values
   // ****************************************************************
   localparam logic [3:0] WRITE_LATENCY = 4'h5;
   localparam logic [3:0] BEATS_FOUR = 4'h4;
   localparam logic [3:0] BEATS_EIGHT = 4'h8;
   localparam logic [1:0] BL_RESET = 2'h0;
   localparam logic [15:0] ROW_RESET = 16'h0000;
endpackage

// [ddr3_cmd_decoder.sv]
// Device-side command decoder for a DDR3 die: mode, activate, precharge,
// refresh, read and write commands; write beats go out as a store port.
// Assumes the memory clock and all pins are asynchronous to ref_clk_i,
// which must run at least four times faster than the memory clock.
//
// The pin synchroniser depth and the store-port write outputs are this design's own decisions.
module ddr3_cmd_decoder (
   input wire logic ref_clk_i, // 20 MHz system clock
   input wire logic rst_i, // Async reset, active high
   input wire logic ck_i, // Memory clock from controller
   input wire logic cs_n_i, // Chip select, low active
   input wire logic ras_n_i, // Row strobe, low active
   input wire logic cas_n_i, // Column strobe, low active
   input wire logic we_n_i, // Write enable, low active
   input wire logic [2:0] ba_i, // Bank address
   input wire logic [15:0] addr_i, // Address bus
   input wire logic [7:0] dq_i, // Write data lines
   input wire logic write_byte_mask_i, // Mask or termination strobe
   output logic rd_start_o, // Read accepted, one-cycle pulse
   output logic wr_en_o, // Store one beat, one-cycle pulse
   output logic [2:0] bank_o, // Bank of the column command
   output logic [9:0] col_o, // Column of read start or write beat
   output logic [7:0] wr_data_o, // Beat data
   output logic burst_eight_o, // Burst is eight beats
   output logic refresh_o, // Refresh accepted, one-cycle pulse
   output logic [15:0] refresh_row_o, // Row refreshed by last refresh
   output logic [7:0] bank_open_o, // Banks with an open row
   output logic term_strobe_o // Mask line used as termination strobe
);
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_WAIT = 2'b01,
      WR_DATA = 2'b10
   } wr_state_e;

   // All checks below run on the system clock and pause during reset
   default clocking chk_clk @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   // Two-flop synchronisers, then one more stage for edge finding
   localparam int SW = 33;
   logic [SW-1:0] meta_q, sync_q, prev_q;
   logic [SW-1:0] pins;
   logic ck_s, ck_p, rise, fall;
   logic [3:0] cmd;
   logic [2:0] ba_s;
   logic [15:0] addr_s;
   logic [7:0] dq_s;
   logic mask_s;
   logic [1:0] bl_mode_q, bl_mode_d;
   logic term_q, term_d;
   wr_state_e state_q, state_d;
   logic [3:0] cnt_q, cnt_d, beats_q, beats_d;
   logic rd_q, rd_d, wr_q, wr_d, ref_q, ref_d, b8_q, b8_d;
   logic [2:0] bank_q, bank_d;
   logic [9:0] col_q, col_d, base_q, base_d;
   logic [7:0] data_q, data_d, open_q, open_d;
   logic [15:0] row_q, row_d;
   logic eight;

   // ****************************************************************
   // Pin capture
   // ****************************************************************
   assign pins = {ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i,
                  dq_i, write_byte_mask_i};
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Fields of the settled pins, edges of the memory clock
   assign ck_s = sync_q[32];
   assign ck_p = prev_q[32];
   assign rise = ck_s & ~ck_p;
   assign fall = ~ck_s & ck_p;
   assign cmd = sync_q[31:28];
   assign ba_s = sync_q[27:25];
   assign addr_s = sync_q[24:9];
   assign dq_s = sync_q[8:1];
   assign mask_s = sync_q[0];

   // Burst length from mode field and A12; reserved code runs as eight
   always_comb begin
      unique case (bl_mode_q)
         ddr3_cmd_pkg::BL_ON_THE_FLY:
            eight = addr_s[ddr3_cmd_pkg::BL_SELECT_BIT]; // RQ5
         ddr3_cmd_pkg::BL_FIXED_FOUR: eight = 1'b0; // RQ9
         default: eight = 1'b1; // RQ8
      endcase
   end

   // ****************************************************************
   // Command decode and write engine
   // ****************************************************************
   always_comb begin
      bl_mode_d = bl_mode_q;
      term_d = term_q;
      state_d = state_q;
      cnt_d = cnt_q;
      beats_d = beats_q;
      rd_d = 1'b0;
      wr_d = 1'b0;
      ref_d = 1'b0;
      b8_d = b8_q;
      bank_d = bank_q;
      col_d = col_q;
      base_d = base_q;
      data_d = data_q;
      open_d = open_q;
      row_d = row_q;
      if (rise) begin
         unique case (cmd)
            ddr3_cmd_pkg::CMD_MODE: begin
               if (ba_s == ddr3_cmd_pkg::SEL_MODE_ZERO) begin
                  bl_mode_d = addr_s[1:0];
               end
               if (ba_s == ddr3_cmd_pkg::SEL_MODE_ONE) begin
                  term_d = addr_s[ddr3_cmd_pkg::TERM_STROBE_BIT];
               end
            end
            ddr3_cmd_pkg::CMD_REFRESH: begin
               // Address bus ignored; internal row counter advances
               ref_d = 1'b1; // RQ15
               row_d = row_q + 16'h0001; // RQ17
               open_d = 8'h00; // RQ17
            end
            ddr3_cmd_pkg::CMD_ACTIVATE: open_d[ba_s] = 1'b1;
            ddr3_cmd_pkg::CMD_PRECHARGE: begin
               if (addr_s[ddr3_cmd_pkg::AUTO_PRE_BIT]) begin
                  open_d = 8'h00;
               end else begin
                  open_d[ba_s] = 1'b0;
               end
            end
            ddr3_cmd_pkg::CMD_READ: begin
               // Mask line is not looked at for reads
               rd_d = 1'b1; // RQ12
               b8_d = eight;
               bank_d = ba_s;
               col_d = addr_s[9:0]; // RQ6
            end
            ddr3_cmd_pkg::CMD_WRITE: begin
               if (state_q == WR_IDLE) begin
                  state_d = WR_WAIT;
                  cnt_d = 4'h1;
                  b8_d = eight;
                  beats_d = eight ? ddr3_cmd_pkg::BEATS_EIGHT
                                  : ddr3_cmd_pkg::BEATS_FOUR;
                  bank_d = ba_s;
                  base_d = addr_s[9:0]; // RQ6
               end
            end
            default: ;
         endcase
      end
      // Beat count is fixed once started, so bad strobes cannot stall it
      unique case (state_q)
         WR_IDLE: ;
         WR_WAIT: begin
            if (rise) begin
               if (cnt_q == ddr3_cmd_pkg::WRITE_LATENCY) begin
                  state_d = WR_DATA;
                  cnt_d = 4'h0;
               end else begin
                  cnt_d = cnt_q + 4'h1;
               end
            end
         end
         WR_DATA: begin
            if (rise | fall) begin
               // Mask sampled on the same edges as the data
               wr_d = ~mask_s | term_q; // RQ11 RQ12
               data_d = dq_s; // RQ10
               col_d = {base_q[9:3], 3'(base_q[2:0] + cnt_q[2:0])};
               cnt_d = cnt_q + 4'h1;
               if (cnt_q + 4'h1 == beats_q) begin
                  state_d = WR_IDLE; // RQ10
               end
            end
         end
         default: state_d = WR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bl_mode_q <= ddr3_cmd_pkg::BL_RESET;
         term_q <= 1'b0;
         state_q <= WR_IDLE;
         cnt_q <= 4'h0;
         beats_q <= 4'h0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         ref_q <= 1'b0;
         b8_q <= 1'b1;
         bank_q <= 3'h0;
         col_q <= 10'h000;
         base_q <= 10'h000;
         data_q <= 8'h00;
         open_q <= 8'h00;
         row_q <= ddr3_cmd_pkg::ROW_RESET;
      end else begin
         bl_mode_q <= bl_mode_d;
         term_q <= term_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         beats_q <= beats_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         ref_q <= ref_d;
         b8_q <= b8_d;
         bank_q <= bank_d;
         col_q <= col_d;
         base_q <= base_d;
         data_q <= data_d;
         open_q <= open_d;
         row_q <= row_d;
      end
   end

   // Outputs straight from flops
   assign rd_start_o = rd_q;
   assign wr_en_o = wr_q;
   assign bank_o = bank_q;
   assign col_o = col_q;
   assign wr_data_o = data_q;
   assign burst_eight_o = b8_q;
   assign refresh_o = ref_q;
   assign refresh_row_o = row_q;
   assign bank_open_o = open_q;
   assign term_strobe_o = term_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_write_cmd;
      rise && cmd == ddr3_cmd_pkg::CMD_WRITE && state_q == WR_IDLE;
   endsequence
   sequence s_refresh_cmd;
      rise && cmd == ddr3_cmd_pkg::CMD_REFRESH;
   endsequence

   fly_burst_a: assert property ( // RQ5
      rise && cmd == ddr3_cmd_pkg::CMD_READ
      && bl_mode_q == ddr3_cmd_pkg::BL_ON_THE_FLY
      |=> rd_start_o && burst_eight_o == $past(addr_s[12]))
      else $error("on-the-fly burst length wrong");
   col_no_a12_a: assert property ( // RQ6
      rise && cmd == ddr3_cmd_pkg::CMD_READ |=> col_o == $past(addr_s[9:0]))
      else $error("read column not taken from low address bits");
   fixed_eight_a: assert property ( // RQ8
      rise && cmd == ddr3_cmd_pkg::CMD_READ
      && bl_mode_q == ddr3_cmd_pkg::BL_FIXED_EIGHT |=> burst_eight_o)
      else $error("fixed eight mode gave short burst");
   fixed_four_a: assert property ( // RQ9
      s_write_cmd and bl_mode_q == ddr3_cmd_pkg::BL_FIXED_FOUR
      |=> !burst_eight_o && beats_q == ddr3_cmd_pkg::BEATS_FOUR)
      else $error("fixed four mode gave long burst");
   write_ends_a: assert property ( // RQ10
      state_q == WR_DATA |-> ##[1:40] state_q == WR_IDLE)
      else $error("write engine stuck in data phase");
   mask_drop_a: assert property ( // RQ11
      state_q == WR_DATA && (rise || fall) && mask_s && !term_q
      |=> !wr_en_o)
      else $error("masked beat was stored");
   term_mode_a: assert property ( // RQ12
      state_q == WR_DATA && (rise || fall) && term_q
      |=> wr_en_o && wr_data_o == $past(dq_s))
      else $error("termination strobe mode dropped a beat");
   refresh_idle_a: assert property ( // RQ17
      s_refresh_cmd |=> refresh_o && bank_open_o == 8'h00
      && refresh_row_o == $past(row_q) + 16'h0001)
      else $error("refresh left a bank open or row counter stale");
   refresh_decode_a: assert property ( // RQ15
      refresh_o |-> $past(rise) && $past(cmd) == ddr3_cmd_pkg::CMD_REFRESH)
      else $error("refresh pulse without refresh command");
endmodule

// [ddr3_ctrl_model.sv]
// Behavioural memory controller driving the DDR3 command decoder pins.
// Assumes the testbench calls its tasks one at a time.
module ddr3_ctrl_model #(
   parameter int IDLE_CK = 6, // Deselect clocks after each command
   parameter int REFI_CK = 64 // Memory clocks per average refresh interval
) (
   output logic ck_o, // Memory clock, free running
   output logic cs_n_o, // Chip select
   output logic ras_n_o, // Row strobe
   output logic cas_n_o, // Column strobe
   output logic we_n_o, // Write enable
   output logic [2:0] ba_o, // Bank
   output logic [15:0] addr_o, // Address
   output logic [7:0] dq_o, // Write data
   output logic mask_o // Write byte mask
);
   timeunit 1ns;
   timeprecision 1ps;
   // Refresh accounting: owed per interval, paid per refresh
   int owed = 0;
   int paid = 0;
   int ticks = 0;
   // Memory clock, phase unrelated to the system clock
   initial begin
      ck_o = 1'b0;
      #37;
      forever #200 ck_o = ~ck_o;
   end
   // Idle pins
   initial begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
      ba_o = 3'h0;
      addr_o = 16'h0000;
      dq_o = 8'h00;
      mask_o = 1'b0;
   end
   // One command held across a rising edge, then released
   task automatic put(input logic [3:0] code, input logic [2:0] ba,
         input logic [15:0] addr);
      @(negedge ck_o);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= code;
      ba_o <= ba;
      addr_o <= addr;
      @(posedge ck_o);
      @(negedge ck_o);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {1'b1, ~code[2:0]};
      ba_o <= ~ba;
      addr_o <= ~addr;
   endtask
   // Spacing covers read to precharge, column spacing and refresh cycle
   task automatic command(input logic [3:0] code, input logic [2:0] ba,
         input logic [15:0] addr);
      put(code, ba, addr);
      repeat (IDLE_CK) @(posedge ck_o);
   endtask
   // Write with beats centred on both clock edges from the fall after
   // the fifth rising edge, where the decoder takes its first beat
   task automatic write_burst(input logic [2:0] ba, input logic [15:0] addr,
         input int beats, input logic [7:0] mask, input bit late);
      put(4'h4, ba, addr);
      repeat (5) @(posedge ck_o);
      for (int k = 0; k < beats; k++) begin
         #(late ? 195 : 100); // Late change breaks the setup window
         dq_o <= 8'hA0 + 8'(k);
         mask_o <= mask[k];
         @(ck_o);
      end
      #100;
      dq_o <= ~dq_o;
      mask_o <= ~mask_o;
      repeat (IDLE_CK) @(posedge ck_o);
   endtask
   // Owed count moves only with the memory clock, so it stays frozen
   // whenever that clock is stopped
   always @(posedge ck_o) begin
      if (ticks == REFI_CK - 1) begin
         ticks <= 0;
         owed <= owed + 1;
      end else begin
         ticks <= ticks + 1;
      end
   end
   // Refresh only while fewer than eight are pulled in ahead
   task automatic refresh(input logic [2:0] ba, input logic [15:0] addr);
      while (paid - owed >= 8) @(posedge ck_o);
      paid++;
      command(4'h1, ba, addr);
   endtask
endmodule

// [ddr3_write_precharge_refresh_rules_tb.sv]
// Self-checking bench for the DDR3 command decoder.
// Assumes the controller model drives every memory pin of the decoder.
module ddr3_write_precharge_refresh_rules_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] field; logic [15:0] addr; logic eight;} row_s;
   logic ref_clk_i, rst_i, ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, mask_i;
   logic [2:0] ba_i, bank_o;
   logic [15:0] addr_i, refresh_row_o;
   logic [7:0] dq_i, wr_data_o, bank_open_o;
   logic [9:0] col_o;
   logic rd_start_o, wr_en_o, burst_eight_o, refresh_o, term_strobe_o;
   logic [31:0] cap_q[3][$];
   logic [31:0] v;
   int mismatches = 0;
   int checked = 0;
   row_s rows[6] = '{'{2'h0, 16'h03FF, 1'b1}, '{2'h0, 16'h1001, 1'b1},
      '{2'h1, 16'h0402, 1'b0}, '{2'h1, 16'h1203, 1'b1},
      '{2'h2, 16'h1004, 1'b0}, '{2'h3, 16'h0005, 1'b1}};
   ddr3_cmd_decoder uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ck_i(ck_i),
      .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i),
      .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i), .dq_i(dq_i),
      .write_byte_mask_i(mask_i), .rd_start_o(rd_start_o),
      .wr_en_o(wr_en_o), .bank_o(bank_o), .col_o(col_o),
      .wr_data_o(wr_data_o), .burst_eight_o(burst_eight_o),
      .refresh_o(refresh_o), .refresh_row_o(refresh_row_o),
      .bank_open_o(bank_open_o), .term_strobe_o(term_strobe_o));
   ddr3_ctrl_model ctl (.ck_o(ck_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
      .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i),
      .dq_o(dq_i), .mask_o(mask_i));
   // System clock
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // Capture of read starts, stored beats and refreshes, off the edge
   always @(negedge ref_clk_i) begin
      if (rd_start_o === 1'b1) begin
         cap_q[0].push_back({burst_eight_o, bank_o, col_o});
      end
      if (wr_en_o === 1'b1) cap_q[1].push_back({bank_o, col_o, wr_data_o});
      if (refresh_o === 1'b1) cap_q[2].push_back(refresh_row_o);
   end
   task automatic check(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Bounded wait for a captured event
   task automatic take(input int which, output logic [31:0] r);
      int n;
      n = 0;
      r = 'x;
      while (cap_q[which].size() == 0 && n < 400) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (cap_q[which].size() != 0) r = cap_q[which].pop_front();
   endtask
   task automatic write_check(input logic [2:0] ba, input logic [15:0] addr,
         input int beats, input logic [7:0] mask, input bit late, keep);
      ctl.write_burst(ba, addr, beats, mask, late);
      for (int k = 0; k < beats; k++) begin
         if (keep || !mask[k]) begin
            take(1, v);
            check("beat col", v[20:8],
               {ba, addr[9:3], 3'(addr[2:0] + k)});
            if (!late) check("beat data", v[7:0], 8'hA0 + 8'(k));
         end
      end
      check("extra beats", cap_q[1].size(), 0);
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #2000000;
      mismatches++;
      print_verdict();
   end
   // Main sequence
   initial begin
      rst_i = 1'b1;
      repeat (20) @(posedge ref_clk_i);
      check("reset", {rd_start_o, wr_en_o, refresh_o, burst_eight_o,
         term_strobe_o, bank_open_o, refresh_row_o}, 29'h0200_0000);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         ctl.command(4'h0, ddr3_cmd_pkg::SEL_MODE_ZERO,
            {14'h0, rows[i].field});
         ctl.command(4'h3, 3'(i), 16'h0000);
         ctl.command(4'h5, 3'(i), rows[i].addr);
         take(0, v);
         check("read", v[13:0],
            {rows[i].eight, 3'(i), rows[i].addr[9:0]});
      end
      ctl.command(4'h0, ddr3_cmd_pkg::SEL_MODE_ZERO, 16'h0001);
      write_check(3'h2, 16'h100D, 8, 8'h04, 1'b0, 1'b0);
      write_check(3'h5, 16'h03FE, 4, 8'h00, 1'b0, 1'b0);
      ctl.command(4'h0, ddr3_cmd_pkg::SEL_MODE_ONE, 16'h0800);
      check("term on", term_strobe_o, 1);
      write_check(3'h4, 16'h0010, 4, 8'hFF, 1'b0, 1'b1);
      ctl.command(4'h0, ddr3_cmd_pkg::SEL_MODE_ONE, 16'h0000);
      check("term off", term_strobe_o, 0);
      write_check(3'h1, 16'h1040, 8, 8'h00, 1'b1, 1'b0);
      write_check(3'h1, 16'h1048, 8, 8'h00, 1'b0, 1'b0);
      // Fixed four-beat field overrides A12 high on writes
      ctl.command(4'h0, ddr3_cmd_pkg::SEL_MODE_ZERO, 16'h1002);
      write_check(3'h6, 16'h1020, 4, 8'h00, 1'b0, 1'b0);
      ctl.command(4'h2, 3'h0, 16'h0400);
      check("all closed", bank_open_o, 8'h00);
      for (int n = 1; n <= 3; n++) begin
         ctl.command(4'h3, 3'h3, 16'h0000);
         check("open", bank_open_o, 8'h08);
         ctl.command(4'h2, 3'h3, 16'h0000);
         check("closed", bank_open_o, 8'h00);
         ctl.refresh(3'h7, 16'hFFFF);
         take(2, v);
         check("refresh row", v, ddr3_cmd_pkg::ROW_RESET + 16'(n));
         check("idle", bank_open_o, 8'h00);
      end
      // Mid-run reset clears banks, row counter and the four-beat field
      ctl.command(4'h3, 3'h6, 16'h0000);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (3) @(negedge ref_clk_i);
      check("reset again", {rd_start_o, wr_en_o, refresh_o,
         burst_eight_o, term_strobe_o, bank_open_o, refresh_row_o},
         29'h0200_0000);
      @(posedge ref_clk_i);
      rst_i <= 1'b0;
      ctl.command(4'h3, 3'h6, 16'h0000);
      ctl.command(4'h5, 3'h6, 16'h0007);
      take(0, v);
      check("read after reset", v[13:0], {1'b1, 3'h6, 10'h007});
      print_verdict();
   end
endmodule
